// ---- rtl/asr_pkg.sv ----
// Package: constants for the host-side asynchronous SRAM controller
package asr_pkg;
  // ==========================================================
  // Geometry
  localparam int ADDR_W = 16;
  localparam int DATA_W = 24;
  // ==========================================================
  // Timing at 20 MHz (50 ns period)
  localparam int CLK_PERIOD_NS = 50;
  localparam int T_ACCESS_NS   = 25;   // Address/select to data valid
  localparam int T_PWE_NS      = 20;   // Least write strobe width
  localparam int T_HZ_NS       = 10;   // Data float after read end
  localparam int SYNC_CYC      = 2;    // Sync stages before a pin word is trusted
  // Least times round up, never below one cycle
  localparam int ACC_CYC  = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PWE_CYC  = (T_PWE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TURN_CYC = (T_HZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W    = 4;
  // ==========================================================
  // Controller states
  typedef enum logic [2:0] {
    ASR_IDLE, ASR_RD_SEL, ASR_RD_WAIT, ASR_RD_CAP, ASR_WR_SET, ASR_WR_PULSE,
    ASR_WR_END, ASR_TURN
  } asr_state_e;
endpackage

// ---- rtl/asr_host.sv ----
// Host-side controller driving a 64K x 24 asynchronous static RAM
`timescale 1ns/1ps
// Overview of operation
// - Write happens only while select and write strobe are both low.
// - Read when select and output drive low with write strobe high.
// - Write window is overlap of select low and strobe low.
// - Write data must be valid around the terminating rising edge.
// - Address valid no later than select falling on a read.
module asr_host #(
  parameter int ADDR_W = asr_pkg::ADDR_W,
  parameter int DATA_W = asr_pkg::DATA_W
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // User request port
  input  wire logic              req_valid,
  input  wire logic              req_write,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  output logic                   req_ready,
  output logic                   rd_valid,
  output logic [DATA_W-1:0]      rd_data,
  // Memory pins
  output logic [ADDR_W-1:0]      word_address_lines,
  output logic                   chip_sel_n,
  output logic                   write_strobe_n,
  output logic                   out_drive_n,
  input  wire logic [DATA_W-1:0] shared_data_lines_i,
  output logic [DATA_W-1:0]      shared_data_lines_o,
  output logic                   shared_data_lines_oe
);
  // ==========================================================
  // State and registers
  asr_pkg::asr_state_e       state_ff;
  logic [asr_pkg::CNT_W-1:0] cnt_ff;
  logic [DATA_W-1:0]         din_s1_ff;
  logic [DATA_W-1:0]         din_s2_ff;
  logic [DATA_W-1:0]         din_s3_ff;
  // Decodes shared by several processes
  logic                      take_req;
  logic                      cnt_done;
  logic                      rd_agree;

  // Load value so that a wait lasts n cycles down to zero
  function automatic logic [asr_pkg::CNT_W-1:0] cyc(input int n);
    cyc = asr_pkg::CNT_W'(n - 1);
  endfunction

  // ==========================================================
  // Read data synchroniser; capture waits for stage 2 and 3 to agree
  always_ff @(posedge clk) begin
    din_s1_ff <= shared_data_lines_i;
    din_s2_ff <= din_s1_ff;
    din_s3_ff <= din_s2_ff;
  end

  // ==========================================================
  // Shared decodes: one place for what several processes act on
  assign take_req = (state_ff == asr_pkg::ASR_IDLE) && req_valid && !req_ready;
  assign cnt_done = (cnt_ff == '0);
  // Stages 2 and 3 agreeing means the pin word has settled
  assign rd_agree = (state_ff == asr_pkg::ASR_RD_CAP) && (din_s2_ff == din_s3_ff);

  // ==========================================================
  // Sequencer state: one access at a time, never overlapped
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= asr_pkg::ASR_IDLE;
    end else begin
      case (state_ff)
        asr_pkg::ASR_IDLE: begin
          if (take_req && req_write) begin
            state_ff <= asr_pkg::ASR_WR_SET;
          end else if (take_req) begin
            state_ff <= asr_pkg::ASR_RD_SEL;
          end
        end
        asr_pkg::ASR_RD_SEL: begin
          state_ff <= asr_pkg::ASR_RD_WAIT;
        end
        asr_pkg::ASR_RD_WAIT: begin
          if (cnt_done) begin
            state_ff <= asr_pkg::ASR_RD_CAP;
          end
        end
        asr_pkg::ASR_RD_CAP: begin
          // Waits while the pins keep moving; a bus that never settles stalls here
          if (rd_agree) begin
            state_ff <= asr_pkg::ASR_TURN;
          end
        end
        asr_pkg::ASR_WR_SET: begin
          state_ff <= asr_pkg::ASR_WR_PULSE;
        end
        asr_pkg::ASR_WR_PULSE: begin
          if (cnt_done) begin
            state_ff <= asr_pkg::ASR_WR_END;
          end
        end
        asr_pkg::ASR_WR_END: begin
          state_ff <= asr_pkg::ASR_TURN;
        end
        asr_pkg::ASR_TURN: begin
          // Turnaround gap so the two drivers never overlap
          if (cnt_done) begin
            state_ff <= asr_pkg::ASR_IDLE;
          end
        end
        default: begin
          state_ff <= asr_pkg::ASR_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Down counter for access, strobe width and turnaround
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_ff <= '0;
    end else begin
      case (state_ff)
        asr_pkg::ASR_RD_SEL: begin
          // Access time plus synchroniser latency before the word is trusted
          cnt_ff <= cyc(asr_pkg::ACC_CYC + asr_pkg::SYNC_CYC);
        end
        asr_pkg::ASR_RD_CAP: begin
          if (rd_agree) begin
            cnt_ff <= cyc(asr_pkg::TURN_CYC);
          end
        end
        asr_pkg::ASR_WR_SET: begin
          cnt_ff <= cyc(asr_pkg::PWE_CYC);  // Least strobe width
        end
        asr_pkg::ASR_WR_END: begin
          cnt_ff <= '0;
        end
        asr_pkg::ASR_RD_WAIT, asr_pkg::ASR_WR_PULSE, asr_pkg::ASR_TURN: begin
          if (!cnt_done) begin
            cnt_ff <= cnt_ff - 1'b1;
          end
        end
        default: begin
          cnt_ff <= '0;
        end
      endcase
    end
  end

  // ==========================================================
  // User side: take pulse, read pulse and the held read word
  always_ff @(posedge clk) begin
    if (rst) begin
      req_ready <= 1'b0;
      rd_valid  <= 1'b0;
      rd_data   <= '0;
    end else begin
      req_ready <= take_req;  // One-cycle pulse per accepted request
      rd_valid  <= rd_agree;  // Stands for one cycle only
      if (rd_agree) begin
        rd_data <= din_s3_ff;  // Held until the next read completes
      end
    end
  end

  // ==========================================================
  // Address and write data: set at take, a cycle before select falls
  always_ff @(posedge clk) begin
    if (rst) begin
      word_address_lines   <= '0;
      shared_data_lines_o  <= '0;
      shared_data_lines_oe <= 1'b0;
    end else if (take_req) begin
      word_address_lines <= req_addr;  // Address before select
      if (req_write) begin
        shared_data_lines_o  <= req_wdata;
        shared_data_lines_oe <= 1'b1;  // Out drive held high meanwhile
      end else begin
        shared_data_lines_oe <= 1'b0;  // Released before out drive falls
      end
    end else if (state_ff == asr_pkg::ASR_WR_END) begin
      // Data held one cycle past the strobe rise for hold time
      shared_data_lines_oe <= 1'b0;
    end
  end

  // ==========================================================
  // Control pins; all idle high so the memory sits deselected
  always_ff @(posedge clk) begin
    if (rst) begin
      chip_sel_n     <= 1'b1;  // Deselected, low power
      write_strobe_n <= 1'b1;
      out_drive_n    <= 1'b1;
    end else begin
      case (state_ff)
        asr_pkg::ASR_IDLE: begin
          chip_sel_n     <= 1'b1;
          write_strobe_n <= 1'b1;
          out_drive_n    <= 1'b1;
        end
        asr_pkg::ASR_RD_SEL: begin
          chip_sel_n  <= 1'b0;  // Read: select and drive low, strobe high
          out_drive_n <= 1'b0;
        end
        asr_pkg::ASR_RD_CAP: begin
          if (rd_agree) begin
            chip_sel_n  <= 1'b1;
            out_drive_n <= 1'b1;  // Device floats again
          end
        end
        asr_pkg::ASR_WR_SET: begin
          // Overlap of select and strobe opens the write
          chip_sel_n     <= 1'b0;
          write_strobe_n <= 1'b0;
        end
        asr_pkg::ASR_WR_PULSE: begin
          if (cnt_done) begin
            write_strobe_n <= 1'b1;  // Strobe rise ends the write
          end
        end
        asr_pkg::ASR_WR_END: begin
          // Select rises a cycle later, never together with the strobe
          chip_sel_n <= 1'b1;
        end
        default: begin
          // Pins hold through waits and turnaround
        end
      endcase
    end
  end
endmodule

// ---- test/asr_sram_model.sv ----
// Partner model: behavioural 64K x 24 static RAM on the controller pins
`timescale 1ns/1ps
module asr_sram_model (
  // Memory pins
  input  wire logic [15:0] addr,
  input  wire logic        cs_n,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic [23:0] host_d,
  input  wire logic        host_oe,
  output logic      [23:0] bus_d
);
  // ==========================================================
  // Storage and drive
  logic [23:0] mem [0:65535];
  logic [23:0] last_q = 24'h000000;
  wire         rd_en  = !cs_n && !oe_n && we_n;
  // Transparent store while select and strobe overlap
  always @* if (!cs_n && !we_n) mem[addr] = host_d;
  // Released bus shows the inverse of its last value, never a held copy
  always @* if (host_oe || rd_en) last_q = host_oe ? host_d : mem[addr];
  assign bus_d = host_oe ? host_d : (rd_en ? mem[addr] : ~last_q);
endmodule

// ---- test/asr_host_sva.sv ----
// Checker: pin protocol of the SRAM controller
`timescale 1ns/1ps
module asr_host_sva (
  // Watched ports
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        req_valid,
  input wire logic        req_write,
  input wire logic        req_ready,
  input wire logic        rd_valid,
  input wire logic [15:0] word_address_lines,
  input wire logic        chip_sel_n,
  input wire logic        write_strobe_n,
  input wire logic        out_drive_n,
  input wire logic        shared_data_lines_oe
);
  // ==========================================================
  // Sequences and assertions
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_rd_take; req_valid && req_ready && !req_write; endsequence
  sequence s_wr_take; req_valid && req_ready && req_write; endsequence
  a_read_answer: assert property (s_rd_take |-> ##[5:20] rd_valid)
    else $error("read gave no data");
  a_write_start: assert property (s_wr_take |-> ##[0:3] !write_strobe_n)
    else $error("write strobe missing");
  a_strobe_qual: assert property (!write_strobe_n |-> !chip_sel_n && out_drive_n)
    else $error("strobe without select");
  a_write_end: assert property ($rose(write_strobe_n) |-> !chip_sel_n && shared_data_lines_oe)
    else $error("write end badly ordered");
  a_no_contention: assert property (!out_drive_n |-> !shared_data_lines_oe && write_strobe_n)
    else $error("bus contention");
  a_addr_steady: assert property (!chip_sel_n && !$fell(chip_sel_n) |-> $stable(word_address_lines))
    else $error("address moved while selected");
  a_addr_setup: assert property ($fell(chip_sel_n) |-> $stable(word_address_lines))
    else $error("address changed as select fell");
  a_read_release: assert property (rd_valid |-> chip_sel_n && out_drive_n && !shared_data_lines_oe)
    else $error("pins not released after read");
endmodule
bind asr_host asr_host_sva u_sva (.*);

// ---- test/asr_host_tb.sv ----
// Testbench for the host-side asynchronous SRAM controller
`timescale 1ns/1ps
module asr_host_tb;
  // ==========================================================
  // Signals, clock and instances
  logic        clk = 1'b0, rst = 1'b1, req_valid = 1'b0, req_write = 1'b0;
  logic [15:0] req_addr = 16'h0000, addr;
  logic [23:0] req_wdata = 24'h000000, rd_data, d_o, bus_d;
  logic        req_ready, rd_valid, cs_n, we_n, oe_n, d_oe;
  int          failures = 0, n_tests = 0;
  initial forever #25 clk = ~clk;
  asr_host u_dut (.clk(clk), .rst(rst), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready), .rd_valid(rd_valid),
    .rd_data(rd_data), .word_address_lines(addr), .chip_sel_n(cs_n), .write_strobe_n(we_n),
    .out_drive_n(oe_n), .shared_data_lines_i(bus_d), .shared_data_lines_o(d_o),
    .shared_data_lines_oe(d_oe));
  asr_sram_model u_mem (.addr(addr), .cs_n(cs_n), .we_n(we_n), .oe_n(oe_n), .host_d(d_o),
    .host_oe(d_oe), .bus_d(bus_d));
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    if (failures == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // One transfer; a lost handshake counts as a mismatch and ends the run
  task automatic xfer(input logic wr, input logic [15:0] a, input logic [23:0] d);
    int i;
    int j;
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    req_valid = 1'b1;
    for (i = 0; i < 20 && req_ready !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    for (j = 0; !wr && j < 20 && rd_valid !== 1'b1; j++) begin
      @(posedge clk);
      #1;
    end
    if (i == 20 || j == 20) begin
      failures++;
      end_of_test();
    end
    if (!wr) check(rd_data, d);
    repeat (7) @(posedge clk);
    #1;
  endtask
  // Extreme addresses written back to back, read in reverse
  task automatic t_bounds;
    xfer(1'b1, 16'hFFFF, 24'hA5C3F0);
    xfer(1'b1, 16'h0000, 24'h5A3C0F);
    xfer(1'b0, 16'h0000, 24'h5A3C0F);
    xfer(1'b0, 16'hFFFF, 24'hA5C3F0);
  endtask
  // A second write to one word replaces the first
  task automatic t_overwrite;
    xfer(1'b1, 16'h8001, 24'hFFFFFF);
    xfer(1'b1, 16'h8001, 24'h000001);
    xfer(1'b0, 16'h8001, 24'h000001);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    #1;
    rst = 1'b0;
    t_bounds();
    t_overwrite();
    check({23'h00000, cs_n}, 24'h000001);
    end_of_test();
  end
endmodule
